// >>> rtl/standby_subtract_swap_exec.sv
// standby, subtract, nibble exchange and direction load execution with a wishbone slave
// assumes a classic wishbone master on i_clk; instructions arrive as bus writes
//
// Notes on behaviour
// - standby opcode is one fixed twelve-bit word, one cycle, no operands
// - standby sets expiry bit, clears nap-entered bit, other flags kept
// - standby zeroes watchdog count, and prescaler when assigned to watchdog
// - subtract is file minus accumulator; updates carry, half borrow, zero
// - subtract destination bit 0 to accumulator, 1 back to file register
// - nibble exchange swaps bits 3:0 and 7:4 of the file register
// - nibble exchange destination 0 to accumulator, 1 back to file register
// - direction load copies accumulator to direction register 5, 6 or 7
//
// The address map and the Wishbone interface to the registers were decided locally.
`include "sse_defs.svh"
module standby_subtract_swap_exec (
    // clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_reset,
    input  wire logic        i_ce,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    // wake-up request from outside the core
    input  wire logic        i_wake,
    // core side
    output logic             o_osc_run,
    output logic             o_fetch_halt,
    output logic      [7:0]  o_dir5,
    output logic      [7:0]  o_dir6,
    output logic      [7:0]  o_dir7
);
    import sse_pkg::*;

    exec_state_t st_ff;
    exec_state_t nxt_st;

    logic       bus_req;
    logic       bus_wr;
    logic       bus_rd;
    logic       instr_wr;
    op_kind_t   op_kind;
    logic       dest_file;
    logic [4:0] op_file;
    logic [7:0] file_rd_a;
    logic [7:0] file_rd_b;
    logic       file_we;
    logic [4:0] file_waddr;
    logic [7:0] file_wdata;
    logic [7:0] alu_diff;
    logic       alu_carry;
    logic       alu_half;
    logic       alu_zero;
    logic [7:0] alu_swapped;
    logic       wd_tick;
    logic       exec_any;

    function automatic op_kind_t decode_op(input logic [11:0] w);
        op_kind_t k;
        k = OPK_NONE;
        if (w == `OP_SLEEP) begin
            k = OPK_SLEEP;
        end else if (w[11:6] == `OP_SUB) begin
            k = OPK_SUB;
        end else if (w[11:6] == `OP_SWAP) begin
            k = OPK_SWAP;
        end else if (w[11:3] == `OP_DIR_HI && w[2:0] >= `DIR_FIRST) begin
            k = OPK_DIR;
        end
        return k;
    endfunction

    // one access per strobe: the registered ack blocks a second take
    assign bus_req   = i_wb_cyc && i_wb_stb && !st_ff.ack;
    assign bus_wr    = bus_req && i_wb_we;
    assign bus_rd    = bus_req && !i_wb_we;
    // no fetch while asleep, so an instruction write then is dropped
    assign instr_wr  = bus_wr && (i_wb_adr == `ADR_INSTR) && (i_wb_sel[1:0] == 2'b11)
                       && (st_ff.mode == MODE_RUN);
    assign op_kind   = instr_wr ? decode_op(i_wb_dat[11:0]) : OPK_NONE;
    assign op_file   = i_wb_dat[4:0];
    assign dest_file = i_wb_dat[`DEST_BIT];
    assign exec_any  = (op_kind != OPK_NONE);

    sse_alu u_alu (
        .i_file    (file_rd_a),
        .i_accum   (st_ff.accum),
        .o_diff    (alu_diff),
        .o_carry   (alu_carry),
        .o_half    (alu_half),
        .o_zero    (alu_zero),
        .o_swapped (alu_swapped)
    );

    always_comb begin
        file_we    = 1'b0;
        file_waddr = op_file;
        file_wdata = alu_diff;
        if ((op_kind == OPK_SUB) && dest_file) begin
            file_we = 1'b1;
        end else if ((op_kind == OPK_SWAP) && dest_file) begin
            file_we    = 1'b1;
            file_wdata = alu_swapped;
        end else if (bus_wr && i_wb_adr[`ADR_FILE_BIT] && i_wb_sel[0]) begin
            file_we    = 1'b1;
            file_waddr = i_wb_adr[6:2];
            file_wdata = i_wb_dat[7:0];
        end
    end

    sse_file_regs u_file (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_ce      (i_ce),
        .i_we      (file_we),
        .i_waddr   (file_waddr),
        .i_wdata   (file_wdata),
        .i_raddr_a (op_file),
        .o_rdata_a (file_rd_a),
        .i_raddr_b (i_wb_adr[6:2]),
        .o_rdata_b (file_rd_b)
    );

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ack = bus_req;
        wd_tick    = st_ff.psa ? (st_ff.presc == `BYTE_FULL) : 1'b1;
        nxt_st.presc = st_ff.presc + `BYTE_ONE;
        // watchdog expiry clears the expiry bit and ends a nap
        if (st_ff.wden && wd_tick) begin
            if (st_ff.wdog == `BYTE_FULL) begin
                nxt_st.wdog = `BYTE_ZERO;
                nxt_st.to   = 1'b0;
                nxt_st.mode = MODE_RUN;
            end else begin
                nxt_st.wdog = st_ff.wdog + `BYTE_ONE;
            end
        end
        if ((st_ff.mode == MODE_SLEEP) && i_wake) begin
            nxt_st.mode = MODE_RUN;
        end
        unique case (op_kind)
            OPK_SLEEP: begin
                nxt_st.to   = 1'b1;
                nxt_st.pd   = 1'b0;
                nxt_st.wdog = `BYTE_ZERO;
                if (st_ff.psa) begin
                    nxt_st.presc = `BYTE_ZERO;
                end
                nxt_st.mode = MODE_SLEEP;
            end
            OPK_SUB: begin
                nxt_st.c  = alu_carry;
                nxt_st.dc = alu_half;
                nxt_st.z  = alu_zero;
                if (!dest_file) begin
                    nxt_st.accum = alu_diff;
                end
            end
            OPK_SWAP: begin
                if (!dest_file) begin
                    nxt_st.accum = alu_swapped;
                end
            end
            OPK_DIR: begin
                unique case (i_wb_dat[2:0])
                    `DIR_FIRST: nxt_st.dir5 = st_ff.accum;
                    `DIR_MID:   nxt_st.dir6 = st_ff.accum;
                    `DIR_LAST:  nxt_st.dir7 = st_ff.accum;
                    default:    nxt_st.dir5 = st_ff.dir5;
                endcase
            end
            OPK_NONE: begin
                nxt_st.mode = nxt_st.mode;
            end
        endcase
        if (bus_wr && i_wb_sel[0]) begin
            unique case (i_wb_adr)
                `ADR_ACCUM: nxt_st.accum = i_wb_dat[7:0];
                `ADR_STATUS: begin
                    nxt_st.c  = i_wb_dat[`ST_C];
                    nxt_st.dc = i_wb_dat[`ST_DC];
                    nxt_st.z  = i_wb_dat[`ST_Z];
                end
                `ADR_CONFIG: begin
                    nxt_st.psa  = i_wb_dat[`CFG_PSA];
                    nxt_st.wden = i_wb_dat[`CFG_WDEN];
                end
                default: nxt_st.rdata = st_ff.rdata;
            endcase
        end
        if (bus_rd) begin
            nxt_st.rdata = 32'h0000_0000;
            if (i_wb_adr[`ADR_FILE_BIT]) begin
                nxt_st.rdata = {24'h00_0000, file_rd_b};
            end else begin
                unique case (i_wb_adr)
                    `ADR_ACCUM:  nxt_st.rdata = {24'h00_0000, st_ff.accum};
                    `ADR_STATUS: nxt_st.rdata = {27'h000_0000, st_ff.to, st_ff.pd,
                                                 st_ff.z, st_ff.dc, st_ff.c};
                    `ADR_CONFIG: nxt_st.rdata = {30'h0000_0000, st_ff.wden, st_ff.psa};
                    `ADR_WDOG:   nxt_st.rdata = {24'h00_0000, st_ff.wdog};
                    `ADR_PRESC:  nxt_st.rdata = {24'h00_0000, st_ff.presc};
                    `ADR_DIR5:   nxt_st.rdata = {24'h00_0000, st_ff.dir5};
                    `ADR_DIR6:   nxt_st.rdata = {24'h00_0000, st_ff.dir6};
                    `ADR_DIR7:   nxt_st.rdata = {24'h00_0000, st_ff.dir7};
                    default:     nxt_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_ff       <= '0;
            st_ff.mode  <= MODE_RUN;
            st_ff.pd    <= 1'b1;
            st_ff.to    <= 1'b1;
            st_ff.dir5  <= `DIR_RESET;
            st_ff.dir6  <= `DIR_RESET;
            st_ff.dir7  <= `DIR_RESET;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_wb_dat     = st_ff.rdata;
    assign o_wb_ack     = st_ff.ack;
    assign o_osc_run    = (st_ff.mode == MODE_RUN);
    assign o_fetch_halt = (st_ff.mode == MODE_SLEEP);
    assign o_dir5       = st_ff.dir5;
    assign o_dir6       = st_ff.dir6;
    assign o_dir7       = st_ff.dir7;

    property p_sleep_flags;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SLEEP) && i_ce |=> st_ff.to && !st_ff.pd && !o_osc_run
            && (st_ff.z == $past(st_ff.z)) && (st_ff.c == $past(st_ff.c));
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("standby flags wrong");

    property p_sleep_wdog;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SLEEP) && i_ce && st_ff.psa |=> (st_ff.wdog == 8'h00)
            && (st_ff.presc == 8'h00);
    endproperty
    a_sleep_wdog: assert property (p_sleep_wdog) else $error("watchdog not cleared");

    property p_halt;
        @(posedge i_clk) disable iff (i_reset)
        o_fetch_halt |-> !exec_any && !o_osc_run;
    endproperty
    a_halt: assert property (p_halt) else $error("instruction ran while asleep");

    property p_sub_acc;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SUB) && !dest_file && i_ce |=>
            (st_ff.accum == ($past(file_rd_a) - $past(st_ff.accum)))
            && (st_ff.z == (st_ff.accum == 8'h00));
    endproperty
    a_sub_acc: assert property (p_sub_acc) else $error("subtract result wrong");

    property p_sub_flags;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SUB) && i_ce |=> (st_ff.c == ($past(file_rd_a) >= $past(st_ff.accum)))
            && (st_ff.dc == ($past(file_rd_a[3:0]) >= $past(st_ff.accum[3:0])));
    endproperty
    a_sub_flags: assert property (p_sub_flags) else $error("subtract flags wrong");

    property p_sub_file;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SUB) && dest_file |-> file_we && (file_waddr == i_wb_dat[4:0]);
    endproperty
    a_sub_file: assert property (p_sub_file) else $error("difference not sent to file");

    property p_swap_acc;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SWAP) && !dest_file && i_ce |=>
            (st_ff.accum == {$past(file_rd_a[3:0]), $past(file_rd_a[7:4])});
    endproperty
    a_swap_acc: assert property (p_swap_acc) else $error("exchange result wrong");

    property p_swap_file;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_SWAP) && dest_file && i_ce |=>
            ($past(file_rd_a) == {file_rd_a[3:0], file_rd_a[7:4]}) && $stable(st_ff.accum);
    endproperty
    a_swap_file: assert property (p_swap_file) else $error("exchange write-back wrong");

    property p_dir_load;
        @(posedge i_clk) disable iff (i_reset)
        (op_kind == OPK_DIR) && (i_wb_dat[2:0] == 3'h6) && i_ce |=>
            (o_dir6 == $past(st_ff.accum)) && $stable(st_ff.c) && $stable(st_ff.z);
    endproperty
    a_dir_load: assert property (p_dir_load) else $error("direction load wrong");

    property p_ack;
        @(posedge i_clk) disable iff (i_reset)
        bus_req && i_ce |=> o_wb_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no ack after request");

    c_sleep_wake: cover property (@(posedge i_clk) o_fetch_halt ##1 o_osc_run);
    c_sub_zero:   cover property (@(posedge i_clk) (op_kind == OPK_SUB) && alu_zero);
    c_swap_file:  cover property (@(posedge i_clk) (op_kind == OPK_SWAP) && dest_file);
    c_dir_load:   cover property (@(posedge i_clk) (op_kind == OPK_DIR));

endmodule

// >>> rtl/sse_defs.svh
// offsets, field positions, opcodes and reset values of the exec block
// assumes inclusion by bare name from every rtl file that needs them
`ifndef SSE_DEFS_SVH
`define SSE_DEFS_SVH

// wishbone byte addresses, one aligned word each
`define ADR_INSTR      8'h00
`define ADR_ACCUM      8'h04
`define ADR_STATUS     8'h08
`define ADR_CONFIG     8'h0C
`define ADR_WDOG       8'h10
`define ADR_PRESC      8'h14
`define ADR_DIR5       8'h18
`define ADR_DIR6       8'h1C
`define ADR_DIR7       8'h20
`define ADR_FILE_BIT   7

// status bits
`define ST_C           0
`define ST_DC          1
`define ST_Z           2
`define ST_PD          3
`define ST_TO          4

// config bits
`define CFG_PSA        0
`define CFG_WDEN       1

// instruction encodings
`define OP_SLEEP       12'h003
`define OP_SUB         6'h02
`define OP_SWAP        6'h0E
`define OP_DIR_HI      9'h000
`define DIR_FIRST      3'h5
`define DIR_MID        3'h6
`define DIR_LAST       3'h7
`define DEST_BIT       5

// reset and count values
`define DIR_RESET      8'hFF
`define BYTE_ZERO      8'h00
`define BYTE_FULL      8'hFF
`define BYTE_ONE       8'h01

`endif

// >>> rtl/sse_pkg.sv
// types shared by the exec block and its file register store
// assumes nothing beyond a systemverilog compiler
package sse_pkg;

    typedef enum logic [1:0] {
        MODE_RUN   = 2'b00,
        MODE_SLEEP = 2'b01
    } mode_t;

    typedef enum logic [2:0] {
        OPK_NONE  = 3'b000,
        OPK_SLEEP = 3'b001,
        OPK_SUB   = 3'b010,
        OPK_SWAP  = 3'b011,
        OPK_DIR   = 3'b100
    } op_kind_t;

    typedef struct packed {
        mode_t       mode;
        logic [7:0]  accum;
        logic        c;
        logic        dc;
        logic        z;
        logic        pd;
        logic        to;
        logic        psa;
        logic        wden;
        logic [7:0]  wdog;
        logic [7:0]  presc;
        logic [7:0]  dir5;
        logic [7:0]  dir6;
        logic [7:0]  dir7;
        logic        ack;
        logic [31:0] rdata;
    } exec_state_t;

    typedef struct packed {
        logic [31:0][7:0] mem;
    } file_state_t;

endpackage

// >>> rtl/sse_alu.sv
// subtract and nibble exchange datapath of the exec block
// assumes operands stable for the whole cycle; purely combinational
`include "sse_defs.svh"
module sse_alu (
    // operands
    input  wire logic [7:0] i_file,
    input  wire logic [7:0] i_accum,
    // results
    output logic      [7:0] o_diff,
    output logic            o_carry,
    output logic            o_half,
    output logic            o_zero,
    output logic      [7:0] o_swapped
);
    import sse_pkg::*;

    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // carry set means no borrow, as in an add of the complement
    always_comb begin
        full_sum  = {1'b0, i_file} + {1'b0, ~i_accum} + 9'h001;
        low_sum   = {1'b0, i_file[3:0]} + {1'b0, ~i_accum[3:0]} + 5'h01;
        o_diff    = full_sum[7:0];
        o_carry   = full_sum[8];
        o_half    = low_sum[4];
        o_zero    = (full_sum[7:0] == `BYTE_ZERO);
        o_swapped = {i_file[3:0], i_file[7:4]};
    end

endmodule

// >>> rtl/sse_file_regs.sv
// thirty-two byte file register store, one write and two read ports
// assumes the caller never needs write-through on the same edge
module sse_file_regs (
    // clock and control
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_ce,
    // write port
    input  wire logic       i_we,
    input  wire logic [4:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    // read ports
    input  wire logic [4:0] i_raddr_a,
    output logic      [7:0] o_rdata_a,
    input  wire logic [4:0] i_raddr_b,
    output logic      [7:0] o_rdata_b
);
    import sse_pkg::*;

    file_state_t st_ff;
    file_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (i_we) begin
            nxt_st.mem[i_waddr] = i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st_ff <= '0;
        end else if (i_ce) begin
            st_ff <= nxt_st;
        end
    end

    assign o_rdata_a = st_ff.mem[i_raddr_a];
    assign o_rdata_b = st_ff.mem[i_raddr_b];

endmodule

// >>> test/standby_subtract_swap_exec_tb_top.sv
// self-checking bench for the exec block, driven over its wishbone slave
// assumes the rtl register map from sse_defs.svh and a single 100 MHz clock
`include "sse_defs.svh"
module standby_subtract_swap_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sse_pkg::*;

    logic        clk    = 1'b0;
    logic        reset  = 1'b1;
    logic        ce     = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we  = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [31:0] wb_wd  = 32'h0;
    logic [3:0]  wb_sel = 4'hF;
    logic        wake   = 1'b0;
    logic [31:0] wb_rd;
    logic        wb_ack;
    logic        osc_run;
    logic        fetch_halt;
    logic [7:0]  dir5;
    logic [7:0]  dir6;
    logic [7:0]  dir7;
    int          errors      = 0;
    int          check_count = 0;

    standby_subtract_swap_exec standby_subtract_swap_exec_inst (
        .i_clk        (clk),
        .i_reset      (reset),
        .i_ce         (ce),
        .i_wb_cyc     (wb_cyc),
        .i_wb_stb     (wb_stb),
        .i_wb_we      (wb_we),
        .i_wb_adr     (wb_adr),
        .i_wb_dat     (wb_wd),
        .i_wb_sel     (wb_sel),
        .o_wb_dat     (wb_rd),
        .o_wb_ack     (wb_ack),
        .i_wake       (wake),
        .o_osc_run    (osc_run),
        .o_fetch_halt (fetch_halt),
        .o_dir5       (dir5),
        .o_dir6       (dir6),
        .o_dir7       (dir7)
    );

    always #5 clk = ~clk;

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    // called just after a rising edge; holds the request until ack is sampled
    task automatic wb_cycle(input logic we, input logic [7:0] adr,
                            input logic [31:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_wd  <= wd;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            test_done();
        end
        rd = wb_rd;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] dummy;
        wb_cycle(1'b1, adr, d, dummy);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] v;
        wb_cycle(1'b0, adr, 32'h0, v);
        check(v, exp);
    endtask

    // waits for the core to run again; returns cycles spent
    task automatic wait_run(input int limit, output int n);
        n = 0;
        while (osc_run !== 1'b1 && n < limit) begin
            @(posedge clk);
            n++;
        end
        if (n >= limit) begin
            errors++;
            test_done();
        end
    endtask

    function automatic logic [7:0] fa(input logic [4:0] f);
        return 8'h80 + {1'b0, f, 2'b00};
    endfunction

    logic [7:0]  sf [4] = '{8'h03, 8'h02, 8'h01, 8'h80};
    logic [7:0]  sa [4] = '{8'h02, 8'h02, 8'h02, 8'h0F};
    logic [4:0]  sx [4] = '{5'd3, 5'd0, 5'd31, 5'd17};
    logic        sd [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    initial begin
        logic [7:0]  diff;
        logic [7:0]  st;
        logic [31:0] v;
        int          n;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);

        // reset state, read-only fields and an unmapped place
        check(osc_run, 1'b1);
        check(fetch_halt, 1'b0);
        check({dir7, dir6, dir5}, 24'hFFFFFF);
        rd_chk(`ADR_ACCUM, 32'h0);
        wr(`ADR_STATUS, 32'h0);
        rd_chk(`ADR_STATUS, 32'h18);
        wr(`ADR_DIR5, 32'h0);
        check(dir5, 8'hFF);
        wr(8'h40, 32'hA5);
        rd_chk(8'h40, 32'h0);
        $display("test reset_and_map done");

        // subtract, both destinations, low and high file addresses
        for (int i = 0; i < 4; i++) begin
            wr(fa(sx[i]), {24'h0, sf[i]});
            wr(`ADR_ACCUM, {24'h0, sa[i]});
            wr(`ADR_INSTR, {20'h0, `OP_SUB, sd[i], sx[i]});
            diff = sf[i] - sa[i];
            st = {3'b000, 2'b11, (diff == 8'h00), (sf[i][3:0] >= sa[i][3:0]), (sf[i] >= sa[i])};
            rd_chk(`ADR_STATUS, {24'h0, st});
            rd_chk(fa(sx[i]), {24'h0, sd[i] ? diff : sf[i]});
            rd_chk(`ADR_ACCUM, {24'h0, sd[i] ? sa[i] : diff});
        end
        $display("test subtract done");

        // nibble exchange keeps every status flag
        wr(`ADR_STATUS, 32'h02);
        wr(fa(5'd5), 32'hA5);
        wr(`ADR_INSTR, {20'h0, `OP_SWAP, 1'b0, 5'd5});
        rd_chk(`ADR_ACCUM, 32'h5A);
        rd_chk(fa(5'd5), 32'hA5);
        wr(fa(5'd31), 32'h3C);
        wr(`ADR_INSTR, {20'h0, `OP_SWAP, 1'b1, 5'd31});
        rd_chk(fa(5'd31), 32'hC3);
        rd_chk(`ADR_ACCUM, 32'h5A);
        rd_chk(`ADR_STATUS, 32'h1A);
        $display("test swap done");

        // direction loads, then an operand outside 5..7 that must be ignored
        for (int k = 5; k < 8; k++) begin
            wr(`ADR_ACCUM, 32'h30 + k);
            wr(`ADR_INSTR, k);
        end
        check({dir7, dir6, dir5}, 24'h373635);
        wr(`ADR_INSTR, 32'h004);
        check({dir7, dir6, dir5}, 24'h373635);
        rd_chk(`ADR_STATUS, 32'h1A);
        $display("test direction done");

        // standby with prescaler on the watchdog, then wake by request
        wr(`ADR_STATUS, 32'h05);
        wr(`ADR_CONFIG, 32'h3);
        repeat (600) @(posedge clk);
        wr(`ADR_CONFIG, 32'h1);
        wb_cycle(1'b0, `ADR_WDOG, 32'h0, v);
        check(v !== 32'h0, 1'b1);
        wr(`ADR_ACCUM, 32'h66);
        wr(`ADR_INSTR, 32'h002);
        check(osc_run, 1'b1);
        wr(`ADR_INSTR, {20'h0, `OP_SLEEP});
        check({osc_run, fetch_halt}, 2'b01);
        rd_chk(`ADR_WDOG, 32'h0);
        wb_cycle(1'b0, `ADR_PRESC, 32'h0, v);
        check(v < 32'h10, 1'b1);
        rd_chk(`ADR_STATUS, 32'h15);
        rd_chk(`ADR_ACCUM, 32'h66);
        check(osc_run, 1'b0);
        wr(`ADR_INSTR, 32'h005);
        check(dir5, 8'h35);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        wait_run(10, n);
        check({osc_run, fetch_halt}, 2'b10);
        rd_chk(`ADR_STATUS, 32'h15);
        $display("test standby_wake done");

        // standby with watchdog counting every cycle: expiry wakes the core
        wr(`ADR_CONFIG, 32'h2);
        wr(`ADR_INSTR, {20'h0, `OP_SLEEP});
        wait_run(400, n);
        check(n > 200, 1'b1);
        rd_chk(`ADR_STATUS, 32'h05);
        $display("test standby_expiry done");

        test_done();
    end
endmodule
